// >>> design/rre_pkg.sv
`default_nettype none
package rre_pkg;
   // register byte offsets on the register bus
   localparam logic [7:0] OFS_INSTR   = 8'h00; // opcode to execute
   localparam logic [7:0] OFS_STAT    = 8'h04; // busy, unsupported flag
   localparam logic [7:0] OFS_WORK    = 8'h08; // working_register
   localparam logic [7:0] OFS_STATUS  = 8'h0c; // arithmetic flags
   localparam logic [7:0] OFS_BANK    = 8'h10; // bank_select_register
   localparam logic [7:0] OFS_WSHD    = 8'h14; // working_shadow
   localparam logic [7:0] OFS_SSHD    = 8'h18; // status_shadow
   localparam logic [7:0] OFS_BSHD    = 8'h1c; // bank_select_shadow
   localparam logic [7:0] OFS_TOP     = 8'h20; // stack_top
   localparam logic [7:0] OFS_PC      = 8'h24; // program counter
   localparam logic [7:0] OFS_INTCTL  = 8'h28; // global enables, priority
   localparam logic [7:0] OFS_PCLAT   = 8'h2c; // pc latches
   localparam logic [7:0] OFS_FADDR   = 8'h30; // file memory pointer
   localparam logic [7:0] OFS_FDATA   = 8'h34; // file memory data window
   localparam logic [7:0] OFS_POPS    = 8'h38; // count of stack pops

   // status flag positions
   localparam int ST_C = 0;
   localparam int ST_Z = 2;
   localparam int ST_N = 4;
   // interrupt control bit positions
   localparam int IC_EN_HI = 0; // high_priority_global_enable
   localparam int IC_EN_LO = 1; // low_priority_global_enable
   localparam int IC_IPEN = 2; // priority mode on
   // stat bit positions
   localparam int SB_BUSY  = 0;
   localparam int SB_UNSUP = 1;

   // opcode patterns
   localparam logic [14:0] OPC_RET_INT = 15'h0008; // op[15:1], s in op[0]
   localparam logic [14:0] OPC_RETURN  = 15'h0009; // op[15:1], s in op[0]
   localparam logic [7:0]  OPC_RET_LIT = 8'h0c;    // op[15:8]
   localparam logic [5:0]  OPC_ROT_C   = 6'h0d;    // op[15:10]
   localparam logic [5:0]  OPC_ROT_P   = 6'h11;    // op[15:10]

   // instruction cycle phases
   localparam logic [1:0] PH_Q1 = 2'h0;
   localparam logic [1:0] PH_Q2 = 2'h1;
   localparam logic [1:0] PH_Q3 = 2'h2;
   localparam logic [1:0] PH_Q4 = 2'h3;

   // upper access bank and file memory address width
   localparam logic [3:0] ACC_HI_BANK = 4'hf;
   localparam int         FILE_AW     = 12;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;

   typedef enum logic [1:0] {RRE_IDLE, RRE_EXEC, RRE_FLUSH} rre_st_t;
endpackage
`default_nettype wire

// >>> design/rre_rotate.sv
`timescale 1ns/1ns
`default_nettype none
module rre_rotate (
   // operand side
   input  wire logic [7:0] opnd,
   input  wire logic       carry_in,
   input  wire logic       thru_carry,
   // result side
   output logic [7:0]      result,
   output logic            carry_out,
   output logic            neg,
   output logic            zero
);
   // left rotate; bit 0 comes from the carry or from bit 7
   always_comb begin
      result    = {opnd[6:0], thru_carry ? carry_in : opnd[7]};
      carry_out = thru_carry ? opnd[7] : carry_in;
      neg       = result[7];
      zero      = (result == 8'h00);
   end
endmodule
`default_nettype wire

// >>> design/rre_core.sv
`timescale 1ns/1ns
`default_nettype none
module rre_core #(
   parameter int PC_W = 21 // program counter width
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // axi4-lite write address
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   // axi4-lite write response
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   // axi4-lite read address
   input  wire logic [7:0]  s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   // axi4-lite read data
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   // core side
   output logic [PC_W-1:0]  pc_out,
   output logic             stack_pop,
   output logic [1:0]       phase
);
   import rre_pkg::*;

   // refuse widths the pc register cannot hold on the bus
   if (PC_W < 8 || PC_W > 32) begin : g_chk
      $error("rre_core: PC_W must be 8..32");
   end

   // all state of the block except the file memory
   typedef struct packed {
      logic            aw_held;  // write address taken
      logic [7:0]      awaddr;   // held write address
      logic            w_held;   // write data taken
      logic [31:0]     wdata;    // held write data
      logic [3:0]      wstrb;    // held byte enables
      logic            bvalid;   // write answer pending
      logic [1:0]      bresp;    // write answer code
      logic            rvalid;   // read answer pending
      logic [31:0]     rdata;    // read answer data
      logic [1:0]      rresp;    // read answer code
      logic            pend;     // opcode waiting for a cycle
      logic [15:0]     pend_op;  // waiting opcode
      logic [15:0]     op;       // opcode in execution
      rre_st_t         st;       // sequencer state
      logic [1:0]      q;        // phase within the cycle
      logic [7:0]      work;     // working_register
      logic [7:0]      status;   // arithmetic flags
      logic [3:0]      bank;     // bank_select_register
      logic [7:0]      wshd;     // working_shadow
      logic [7:0]      sshd;     // status_shadow
      logic [3:0]      bshd;     // bank_select_shadow
      logic [PC_W-1:0] top;      // stack_top
      logic [PC_W-1:0] pc;       // program counter
      logic            en_hi;    // high_priority_global_enable
      logic            en_lo;    // low_priority_global_enable
      logic            ipen;     // priority mode
      logic [7:0]      plath;    // pc_latch_high
      logic [4:0]      platu;    // pc_latch_upper
      logic [11:0]     faddr;    // file memory pointer
      logic [7:0]      opnd;     // operand read in phase 2
      logic [7:0]      res;      // result made in phase 3
      logic            res_c;    // carry made in phase 3
      logic            res_n;    // negative made in phase 3
      logic            res_z;    // zero made in phase 3
      logic            unsup;    // sticky: opcode outside this slice
      logic            pop;      // one-cycle stack pop pulse
      logic [7:0]      pops;     // pop counter
   } rre_state_t;

   rre_state_t st_r;                  // registered state
   rre_state_t st_nxt;                // next state
   logic [7:0] file_mem [0:(1<<FILE_AW)-1]; // file registers
   logic [7:0] op_rd;                 // file byte at operand address
   logic [7:0] fd_rd;                 // file byte at software pointer
   logic [11:0] op_addr;              // operand file address
   logic [7:0] rot_res;               // rotator result
   logic       rot_c;                 // rotator carry
   logic       rot_n;                 // rotator negative
   logic       rot_z;                 // rotator zero
   logic       mem_we;                // file memory write strobe
   logic [11:0] mem_wa;               // file memory write address
   logic [7:0] mem_wd;                // file memory write data
   // opcode decode of the instruction in execution
   logic dec_ret_int;
   logic dec_return;
   logic dec_ret_lit;
   logic dec_rot_c;
   logic dec_rot_p;
   logic dec_rot;
   logic dec_ret;
   logic bit_s;                       // fast return bit
   logic bit_d;                       // destination bit
   logic bit_a;                       // access bit

   // byte-lane merge for register writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] m;
      m = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            m[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return m;
   endfunction

   // decode from the held opcode, not the bus, so it stays stable all cycle
   always_comb begin
      dec_ret_int = (st_r.op[15:1] == OPC_RET_INT);
      dec_return  = (st_r.op[15:1] == OPC_RETURN);
      dec_ret_lit = (st_r.op[15:8] == OPC_RET_LIT);
      dec_rot_c   = (st_r.op[15:10] == OPC_ROT_C);
      dec_rot_p   = (st_r.op[15:10] == OPC_ROT_P);
      dec_rot     = dec_rot_c | dec_rot_p;
      dec_ret     = dec_ret_int | dec_return | dec_ret_lit;
      bit_s      = st_r.op[0];
      bit_d      = st_r.op[9];
      bit_a      = st_r.op[8];
   end

   // operand address: access bank or the selected bank
   always_comb begin
      if (!bit_a) begin
         op_addr = st_r.op[7] ? {ACC_HI_BANK, st_r.op[7:0]}
                              : {4'h0, st_r.op[7:0]};
      end else begin
         op_addr = {st_r.bank, st_r.op[7:0]};
      end
   end

   assign op_rd = file_mem[op_addr];
   assign fd_rd = file_mem[st_r.faddr];

   // rotate data path, shared by both rotate opcodes
   rre_rotate u_rot (
      .opnd       (st_r.opnd),
      .carry_in   (st_r.status[ST_C]),
      .thru_carry (dec_rot_c),
      .result     (rot_res),
      .carry_out  (rot_c),
      .neg        (rot_n),
      .zero       (rot_z)
   );

   // handshakes straight from state
   assign s_awready = !st_r.aw_held && !st_r.bvalid;
   assign s_wready  = !st_r.w_held && !st_r.bvalid;
   assign s_arready = !st_r.rvalid;
   assign s_bvalid  = st_r.bvalid;
   assign s_bresp   = st_r.bresp;
   assign s_rvalid  = st_r.rvalid;
   assign s_rdata   = st_r.rdata;
   assign s_rresp   = st_r.rresp;
   assign pc_out    = st_r.pc;
   assign stack_pop = st_r.pop;
   assign phase     = st_r.q;

   // next state: bus slave first, then the sequencer so it wins a clash
   always_comb begin
      logic [31:0] rd;
      logic [1:0]  rr;
      logic [31:0] wv;
      rd = 32'h0000_0000;
      rr = RESP_OKAY;
      wv = 32'h0000_0000;
      st_nxt = st_r;
      st_nxt.pop = 1'b0;
      mem_we = 1'b0;
      mem_wa = st_r.faddr;
      mem_wd = st_r.wdata[7:0];

      // write channels are taken in either order
      if (s_awvalid && s_awready) begin
         st_nxt.aw_held = 1'b1;
         st_nxt.awaddr  = s_awaddr;
      end
      if (s_wvalid && s_wready) begin
         st_nxt.w_held = 1'b1;
         st_nxt.wdata  = s_wdata;
         st_nxt.wstrb  = s_wstrb;
      end
      if (st_r.bvalid && s_bready) begin
         st_nxt.bvalid = 1'b0;
      end

      // perform a write once address and data are both held
      if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held  = 1'b0;
         st_nxt.bvalid  = 1'b1;
         st_nxt.bresp   = RESP_OKAY;
         case (st_r.awaddr)
            OFS_INSTR: begin
               // a second opcode while one waits is dropped
               if (!st_r.pend) begin
                  wv = lane_merge({16'h0000, st_r.pend_op}, st_r.wdata,
                                  st_r.wstrb);
                  st_nxt.pend    = 1'b1;
                  st_nxt.pend_op = wv[15:0];
               end
            end
            OFS_STAT: begin
               // write one to clear the unsupported flag
               if (st_r.wstrb[0] && st_r.wdata[SB_UNSUP]) begin
                  st_nxt.unsup = 1'b0;
               end
            end
            OFS_WORK: begin
               if (st_r.wstrb[0]) st_nxt.work = st_r.wdata[7:0];
            end
            OFS_STATUS: begin
               if (st_r.wstrb[0]) st_nxt.status = st_r.wdata[7:0];
            end
            OFS_BANK: begin
               if (st_r.wstrb[0]) st_nxt.bank = st_r.wdata[3:0];
            end
            OFS_WSHD: begin
               if (st_r.wstrb[0]) st_nxt.wshd = st_r.wdata[7:0];
            end
            OFS_SSHD: begin
               if (st_r.wstrb[0]) st_nxt.sshd = st_r.wdata[7:0];
            end
            OFS_BSHD: begin
               if (st_r.wstrb[0]) st_nxt.bshd = st_r.wdata[3:0];
            end
            OFS_TOP: begin
               wv = lane_merge(32'(st_r.top), st_r.wdata, st_r.wstrb);
               st_nxt.top = wv[PC_W-1:0];
            end
            OFS_PC: begin
               wv = lane_merge(32'(st_r.pc), st_r.wdata, st_r.wstrb);
               st_nxt.pc = wv[PC_W-1:0];
            end
            OFS_INTCTL: begin
               if (st_r.wstrb[0]) begin
                  st_nxt.en_hi = st_r.wdata[IC_EN_HI];
                  st_nxt.en_lo = st_r.wdata[IC_EN_LO];
                  st_nxt.ipen = st_r.wdata[IC_IPEN];
               end
            end
            OFS_PCLAT: begin
               if (st_r.wstrb[0]) st_nxt.plath = st_r.wdata[7:0];
               if (st_r.wstrb[1]) st_nxt.platu = st_r.wdata[12:8];
            end
            OFS_FADDR: begin
               wv = lane_merge({20'h00000, st_r.faddr}, st_r.wdata,
                               st_r.wstrb);
               st_nxt.faddr = wv[11:0];
            end
            OFS_FDATA: begin
               mem_we = st_r.wstrb[0];
            end
            OFS_POPS: begin
               if (st_r.wstrb[0]) st_nxt.pops = st_r.wdata[7:0];
            end
            default: begin
               st_nxt.bresp = RESP_DECERR;
            end
         endcase
      end

      // read answers one cycle after the address is taken
      if (st_r.rvalid && s_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (s_arvalid && s_arready) begin
         case (s_araddr)
            OFS_INSTR:  rd = {16'h0000, st_r.pend_op};
            OFS_STAT:   rd = {30'h0, st_r.unsup,
                              st_r.pend || (st_r.st != RRE_IDLE)};
            OFS_WORK:   rd = {24'h0, st_r.work};
            OFS_STATUS: rd = {24'h0, st_r.status};
            OFS_BANK:   rd = {28'h0, st_r.bank};
            OFS_WSHD:   rd = {24'h0, st_r.wshd};
            OFS_SSHD:   rd = {24'h0, st_r.sshd};
            OFS_BSHD:   rd = {28'h0, st_r.bshd};
            OFS_TOP:    rd = 32'(st_r.top);
            OFS_PC:     rd = 32'(st_r.pc);
            OFS_INTCTL: rd = {29'h0, st_r.ipen, st_r.en_lo, st_r.en_hi};
            OFS_PCLAT:  rd = {19'h0, st_r.platu, st_r.plath};
            OFS_FADDR:  rd = {20'h0, st_r.faddr};
            OFS_FDATA:  rd = {24'h0, fd_rd};
            OFS_POPS:   rd = {24'h0, st_r.pops};
            default:    rr = RESP_DECERR;
         endcase
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = rd;
         st_nxt.rresp  = rr;
      end

      // phase counter free-runs, four phases per instruction cycle
      st_nxt.q = st_r.q + 2'h1;

      case (st_r.st)
         RRE_IDLE: begin
            // a waiting opcode starts at the next phase 1
            if (st_r.q == PH_Q4 && st_r.pend) begin
               st_nxt.st   = RRE_EXEC;
               st_nxt.op   = st_r.pend_op;
               st_nxt.pend = 1'b0;
            end
         end
         RRE_EXEC: begin
            case (st_r.q)
               PH_Q1: begin
                  // decode; flag opcodes this slice does not serve
                  if (!dec_rot && !dec_ret) begin
                     st_nxt.unsup = 1'b1;   // set wins over a clear
                  end
               end
               PH_Q2: begin
                  if (dec_rot) st_nxt.opnd = op_rd;
               end
               PH_Q3: begin
                  st_nxt.res   = rot_res;
                  st_nxt.res_c = rot_c;
                  st_nxt.res_n = rot_n;
                  st_nxt.res_z = rot_z;
               end
               default: begin
                  // phase 4: commit; pc latches are never touched here
                  if (dec_ret) begin
                     st_nxt.pc   = st_r.top;
                     st_nxt.pop  = 1'b1;
                     st_nxt.pops = st_r.pops + 8'h01;
                  end
                  if ((dec_ret_int || dec_return) && bit_s) begin
                     st_nxt.work   = st_r.wshd;
                     st_nxt.status = st_r.sshd;
                     st_nxt.bank   = st_r.bshd;
                  end
                  if (dec_ret_int) begin
                     // legacy mode sets the one global enable
                     if (!st_r.ipen || !st_r.en_hi) begin
                        st_nxt.en_hi = 1'b1;
                     end else begin
                        st_nxt.en_lo = 1'b1;
                     end
                  end
                  if (dec_ret_lit) begin
                     st_nxt.work = st_r.op[7:0];
                  end
                  if (dec_rot) begin
                     if (!bit_d) begin
                        st_nxt.work = st_r.res;
                     end else begin
                        mem_we = 1'b1;
                        mem_wa = op_addr;
                        mem_wd = st_r.res;
                     end
                     st_nxt.status[ST_N] = st_r.res_n;
                     st_nxt.status[ST_Z] = st_r.res_z;
                     st_nxt.status[ST_C] = st_r.res_c;
                  end
                  // returns spend a second cycle doing nothing
                  if (dec_ret) begin
                     st_nxt.st = RRE_FLUSH;
                  end else if (st_r.pend) begin
                     st_nxt.op   = st_r.pend_op;
                     st_nxt.pend = 1'b0;
                  end else begin
                     st_nxt.st = RRE_IDLE;
                  end
               end
            endcase
         end
         RRE_FLUSH: begin
            // no-op cycle after a return
            if (st_r.q == PH_Q4) begin
               if (st_r.pend) begin
                  st_nxt.st   = RRE_EXEC;
                  st_nxt.op   = st_r.pend_op;
                  st_nxt.pend = 1'b0;
               end else begin
                  st_nxt.st = RRE_IDLE;
               end
            end
         end
         default: begin
            st_nxt.st = RRE_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // file memory holds no reset; a rotate commit wins over a bus write
   always_ff @(posedge sys_clk) begin
      if (mem_we) begin
         file_mem[mem_wa] <= mem_wd;
      end
   end
endmodule
`default_nettype wire

// >>> sim/rre_core_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module rre_core_asserts
   import rre_pkg::*;
#(
   parameter int PC_W = 21 // program counter width
) (
   // clock and reset
   input wire logic            sys_clk,
   input wire logic            nrst,
   // bus handshakes
   input wire logic            s_awready,
   input wire logic [1:0]      s_bresp,
   input wire logic            s_bvalid,
   input wire logic            s_bready,
   input wire logic            s_arvalid,
   input wire logic            s_arready,
   input wire logic [31:0]     s_rdata,
   input wire logic            s_rvalid,
   input wire logic            s_rready,
   // core side
   input wire logic [PC_W-1:0] pc_out,
   input wire logic            stack_pop,
   input wire logic [1:0]      phase
);
   // one clock domain, so one clocking and one reset for all
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   // the first edge after release still sees the phase held in reset
   a_phase_walk: assert property (
      $past(nrst) |-> phase == $past(phase) + 2'h1)
      else $error("phase did not advance by one");
   a_pop_spacing: assert property (stack_pop |=> !stack_pop [*7])
      else $error("stack pop not a lone pulse per return");
   a_pop_after_q4: assert property (stack_pop |-> phase == PH_Q1)
      else $error("stack pop outside the cycle after q4");
   a_pc_cause: assert property (
      $changed(pc_out) |-> stack_pop || $rose(s_bvalid))
      else $error("program counter moved without pop or write");
   a_bresp_hold: assert property (
      s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
      else $error("write response dropped early");
   a_rdata_hold: assert property (
      s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
      else $error("read data dropped early");
   a_ar_block: assert property (s_arready == !s_rvalid)
      else $error("read address ready wrong");
   a_read_turn: assert property (s_arvalid && s_arready |=> s_rvalid)
      else $error("read answer late");
   a_aw_block: assert property (s_bvalid |-> !s_awready)
      else $error("write address taken during response");

   // main scenarios reached
   c_pop: cover property (stack_pop);
   c_decerr: cover property (s_bvalid && s_bresp == RESP_DECERR);
   c_read: cover property (s_rvalid && s_rready);
endmodule

bind rre_core rre_core_asserts #(.PC_W(PC_W)) rre_core_asserts_inst (
   .sys_clk, .nrst, .s_awready, .s_bresp, .s_bvalid, .s_bready, .s_arvalid,
   .s_arready, .s_rdata, .s_rvalid, .s_rready, .pc_out, .stack_pop, .phase);
`default_nettype wire

// >>> sim/return_and_rotate_exec_tb.sv
`timescale 1ns/1ns
`default_nettype none
module return_and_rotate_exec_tb;
   import rre_pkg::*;
   // short names for the offsets used most
   localparam logic [7:0] A_WORK = OFS_WORK;
   localparam logic [7:0] A_BANK = OFS_BANK;
   localparam logic [7:0] A_TOP  = OFS_TOP;
   logic        sys_clk, nrst, s_awvalid, s_wvalid, s_bready;
   logic        s_arvalid, s_rready, s_awready, s_wready, s_bvalid;
   logic        s_arready, s_rvalid, stack_pop;
   logic [7:0]  s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata, rdat;
   logic [3:0]  s_wstrb;
   logic [1:0]  s_bresp, s_rresp, phase, resp;
   logic [20:0] pc_out;
   int          n_errors, checked;

   rre_core rre_core_inst (.sys_clk, .nrst, .s_awaddr, .s_awvalid, .s_awready,
      .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
      .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
      .s_rready, .pc_out, .stack_pop, .phase);

   // 50 mhz clock
   always #10 sys_clk = ~sys_clk;

   // bus write; bready only after bvalid so the hold time is exercised
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ah, wh, bh, bk;
      s_awaddr  <= a;
      s_wdata   <= d;
      s_awvalid <= 1'b1;
      s_wvalid  <= 1'b1;
      forever begin
         @(negedge sys_clk);
         ah   = s_awvalid & s_awready;
         wh   = s_wvalid & s_wready;
         bh   = s_bvalid;
         bk   = s_bvalid & s_bready;
         resp = s_bresp;
         @(posedge sys_clk);
         if (ah) s_awvalid <= 1'b0;
         if (wh) s_wvalid <= 1'b0;
         s_bready <= bh & !bk;
         if (bk) break;
      end
   endtask

   // bus read, same late-ready style
   task automatic rd(input logic [7:0] a);
      logic ah, rv, rk;
      s_araddr  <= a;
      s_arvalid <= 1'b1;
      forever begin
         @(negedge sys_clk);
         ah   = s_arvalid & s_arready;
         rv   = s_rvalid;
         rk   = s_rvalid & s_rready;
         rdat = s_rdata;
         resp = s_rresp;
         @(posedge sys_clk);
         if (ah) s_arvalid <= 1'b0;
         s_rready <= rv & !rk;
         if (rk) break;
      end
   endtask

   task automatic chk(input string nm, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk($sformatf("reg %h", a), e, rdat);
   endtask

   // queue an opcode and poll busy; polling is bounded
   task automatic run(input logic [15:0] op);
      wr(OFS_INSTR, {16'h0, op});
      for (int n = 0; n < 30; n++) begin
         rd(OFS_STAT);
         if (rdat[SB_BUSY] === 1'b0) break;
      end
      // a poll that runs out counts as a mismatch
      chk("busy", 32'h0, {31'h0, rdat[SB_BUSY]});
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // hang guard, far beyond the expected run length
   initial begin
      #400000;
      n_errors++;
      final_report();
   end

   initial begin
      {sys_clk, nrst, s_awvalid, s_wvalid, s_bready, s_arvalid} = '0;
      {s_rready, s_awaddr, s_araddr, s_wdata} = '0;
      s_wstrb = 4'hf;
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      rchk(OFS_PC, 32'h0);
      // carry rotate to working reg; low access bank ignores bank select
      wr(A_BANK, 32'h2);
      wr(OFS_FADDR, 32'h025);
      wr(OFS_FDATA, 32'he6);
      wr(OFS_STATUS, 32'h0);
      run(16'h3425);
      rchk(A_WORK, 32'hcc);
      rchk(OFS_STATUS, 32'h11);
      rchk(OFS_FDATA, 32'he6);
      // plain rotate back to file through bank select, carry kept
      wr(OFS_FADDR, 32'h210);
      wr(OFS_FDATA, 32'hab);
      wr(OFS_STATUS, 32'h1);
      wr(A_WORK, 32'h99);
      run(16'h4710);
      rchk(OFS_FDATA, 32'h57);
      rchk(OFS_STATUS, 32'h01);
      rchk(A_WORK, 32'h99);
      // carry rotate to zero in the upper access bank
      wr(OFS_FADDR, 32'hf80);
      wr(OFS_FDATA, 32'h80);
      wr(OFS_STATUS, 32'h0);
      run(16'h3680);
      rchk(OFS_FDATA, 32'h00);
      rchk(OFS_STATUS, 32'h05);
      // fast interrupt return
      wr(OFS_PCLAT, 32'h1abc);
      wr(A_TOP, 32'h12345);
      wr(OFS_WSHD, 32'h5a);
      wr(OFS_SSHD, 32'h14);
      wr(OFS_BSHD, 32'h7);
      wr(OFS_INTCTL, 32'h0);
      run(16'h0011);
      rchk(OFS_PC, 32'h12345);
      rchk(A_WORK, 32'h5a);
      rchk(OFS_STATUS, 32'h14);
      rchk(A_BANK, 32'h7);
      rchk(OFS_INTCTL, 32'h1);
      // plain interrupt return in priority mode sets the low enable
      wr(OFS_INTCTL, 32'h5);
      wr(OFS_STATUS, 32'h13);
      wr(A_WORK, 32'h33);
      run(16'h0010);
      rchk(OFS_INTCTL, 32'h7);
      rchk(OFS_STATUS, 32'h13);
      rchk(A_WORK, 32'h33);
      // fast then plain subroutine return
      wr(A_TOP, 32'h100);
      run(16'h0013);
      rchk(OFS_PC, 32'h100);
      rchk(A_WORK, 32'h5a);
      wr(A_WORK, 32'h33);
      wr(A_TOP, 32'h200);
      run(16'h0012);
      rchk(OFS_PC, 32'h200);
      rchk(A_WORK, 32'h33);
      // literal return leaves flags alone
      wr(OFS_STATUS, 32'h15);
      wr(A_TOP, 32'h300);
      run(16'h0c7e);
      rchk(A_WORK, 32'h7e);
      rchk(OFS_STATUS, 32'h15);
      rchk(OFS_PC, 32'h300);
      rchk(OFS_PCLAT, 32'h1abc);
      rchk(OFS_POPS, 32'h5);
      // unmapped place refused both ways
      wr(8'h3c, 32'h1);
      chk("write resp", {30'h0, RESP_DECERR}, {30'h0, resp});
      rchk(8'h3c, 32'h0);
      chk("read resp", {30'h0, RESP_DECERR}, {30'h0, resp});
      final_report();
   end
endmodule
`default_nettype wire
